/* error_bank_pkg.sv */
package error_bank_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map, word addresses on the plain port
    localparam logic [3:0] ADDR_STATUS_LO = 4'h0;
    localparam logic [3:0] ADDR_STATUS_HI = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
    localparam int HI_VAL_BIT = 31;
    localparam int HI_OVER_BIT = 30;

    ////////////////////////////////////////////////////////////////////////
    // field values and reset values
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_FIRST = 8'h01;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [1:0] THR_NONE = 2'h0;
    localparam logic [1:0] THR_GREEN = 2'h1;
    localparam logic [1:0] THR_YELLOW = 2'h2;
    localparam logic [1:0] THR_RSVD = 2'h3;
    localparam logic [1:0] AUX_RSVD = 2'h0;
    localparam logic [2:0] L3_NONE = 3'h0;
    localparam logic [2:0] L3_MULTI_CE = 3'h1;
    localparam logic [2:0] L3_MULTI_UE = 3'h2;
    localparam logic [2:0] L3_MULTI_TAG = 3'h3;
    localparam logic [2:0] L3_ONE_CE = 3'h5;
    localparam logic [2:0] L3_ONE_UE = 3'h6;
    localparam logic [2:0] L3_MIXED = 3'h7;
    localparam logic [1:0] L3_RSVD = 2'h0;
    localparam logic [10:0] L3_FIXED = 11'h100;
    localparam logic [63:0] STATUS_RESET = 64'h0000_0000_0000_0000;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [31:0] RD_RESET = 32'h0000_0000;
    localparam int IRQ_LOGGED = 0;
    localparam int IRQ_OVER = 1;
    localparam int IRQ_SAT = 2;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [1:0] rsvd_hi;
        logic [1:0] thr;
        logic syn_valid;
        logic [7:0] syndrome;
        logic [1:0] rsvd_lo;
        logic [1:0] misc_fmt;
        logic [7:0] count;
    } aux_s;

    typedef struct packed {
        logic val;
        logic over;
        logic uc;
        logic en;
        logic misc_valid;
        logic addrv;
        logic pcc;
        aux_s aux;
        logic [15:0] model;
        logic [15:0] machine_check_arch;
    } status_s;

    typedef struct packed {
        logic [10:0] fixed;
        logic [1:0] rsvd;
        logic [2:0] code;
    } l3_code_s;

    typedef struct packed {
        logic valid;
        logic uncorrected;
        logic pcc;
        logic en;
        logic addrv;
        logic misc_valid;
        logic [1:0] misc_fmt;
        logic ecc_syn_valid;
        logic [7:0] syndrome;
        logic thr_track;
        logic thr_above;
        logic is_l3;
        logic ce_one;
        logic ce_multi;
        logic ue_one;
        logic ue_multi;
        logic tag_multi;
        logic [15:0] model_code;
        logic [15:0] mca_code;
    } ev_s;

    typedef struct packed {
        logic [7:0] count;
    } counter_state_s;

    typedef struct packed {
        status_s status;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] rd_data;
        logic irq;
    } top_state_s;

    ////////////////////////////////////////////////////////////////////////
    // saturating step, shared by the counter and the status mirror
    function automatic logic [7:0] sat_inc(input logic [7:0] c);
        return (c == COUNT_MAX) ? c : c + 8'h01;
    endfunction

    // mixed report outranks single-kind ones; uncorrectable before correctable
    function automatic logic [2:0] l3_code(input ev_s ev);
        logic any_ce;
        logic any_ue;
        any_ce = ev.ce_one | ev.ce_multi;
        any_ue = ev.ue_one | ev.ue_multi;
        if (any_ce && any_ue) begin
            return L3_MIXED;
        end else if (ev.ue_multi) begin
            return L3_MULTI_UE;
        end else if (ev.ue_one) begin
            return L3_ONE_UE;
        end else if (ev.ce_multi) begin
            return L3_MULTI_CE;
        end else if (ev.ce_one) begin
            return L3_ONE_CE;
        end else if (ev.tag_multi) begin
            return L3_MULTI_TAG;
        end
        return L3_NONE;
    endfunction

endpackage

/* sat_event_counter.sv */
`timescale 1ns/1ps
module sat_event_counter (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic bump_i,
    output logic [7:0] count_o
);

    error_bank_pkg::counter_state_s state;
    error_bank_pkg::counter_state_s next_state;

    ////////////////////////////////////////////////////////////////////////
    // only the cold reset clears it; nothing software does reaches this
    always_comb begin
        next_state = state;
        if (ce_i && bump_i) begin
            next_state.count = error_bank_pkg::sat_inc(state.count);
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state.count <= error_bank_pkg::COUNT_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign count_o = state.count;

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_CNT_STEP: assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && bump_i && count_o != error_bank_pkg::COUNT_MAX) |=> (count_o == $past(count_o) + 8'h01))
        else $error("counter did not advance on a correctable event");
    AST_CNT_SAT: assert property (@(posedge clock_i) disable iff (rst_i)
        (count_o == error_bank_pkg::COUNT_MAX) |=> (count_o == error_bank_pkg::COUNT_MAX))
        else $error("counter left saturation");
    AST_CNT_IDLE: assert property (@(posedge clock_i) disable iff (rst_i)
        !(ce_i && bump_i) |=> $stable(count_o))
        else $error("counter moved without a correctable event");
    COV_CNT_SAT: cover property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && bump_i && count_o == error_bank_pkg::COUNT_MAX));

endmodule

/* error_bank_info_formatter.sv */
`timescale 1ns/1ps
module error_bank_info_formatter (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    input wire error_bank_pkg::ev_s EVENT_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RD_DATA_O,
    output error_bank_pkg::status_s STATUS_O,
    output logic IRQ_O
);

    error_bank_pkg::top_state_s state;
    error_bank_pkg::top_state_s next_state;
    logic [7:0] count;
    logic bump;
    logic take_ev;
    logic keep_old;
    logic syn_expect;
    logic ev_uc;
    logic ev_misc_info_valid;
    logic [2:0] l3_expect;
    error_bank_pkg::l3_code_s l3_word;
    error_bank_pkg::aux_s aux_new;

    ////////////////////////////////////////////////////////////////////////
    // correctable event counter
    assign bump = EVENT_I.valid && !EVENT_I.uncorrected;

    sat_event_counter counter_u (
        .clock_i(CLOCK_I),
        .rst_i(SYS_RST_I),
        .ce_i(CE_I),
        .bump_i(bump),
        .count_o(count)
    );

    ////////////////////////////////////////////////////////////////////////
    // event classification; a logged uncorrected error is never replaced
    // by a later corrected one, so the latest uncorrected error stays visible
    assign keep_old = state.status.val && state.status.uc && !EVENT_I.uncorrected;
    assign take_ev = CE_I && EVENT_I.valid && !keep_old;
    assign syn_expect = EVENT_I.ecc_syn_valid && !EVENT_I.uncorrected;
    assign ev_uc = EVENT_I.uncorrected;
    assign ev_misc_info_valid = EVENT_I.misc_valid;
    assign l3_expect = error_bank_pkg::l3_code(EVENT_I);

    // level-3 model code word
    always_comb begin
        l3_word.code = l3_expect;
        l3_word.rsvd = error_bank_pkg::L3_RSVD;
        l3_word.fixed = error_bank_pkg::L3_FIXED;
    end

    // auxiliary field, one layout for all error types
    always_comb begin
        aux_new.count = error_bank_pkg::sat_inc(count);
        if (EVENT_I.uncorrected) begin
            aux_new.count = count;
        end
        aux_new.rsvd_lo = error_bank_pkg::AUX_RSVD;
        aux_new.rsvd_hi = error_bank_pkg::AUX_RSVD;
        aux_new.misc_fmt = EVENT_I.misc_valid ? EVENT_I.misc_fmt : 2'h0;
        aux_new.syn_valid = syn_expect;
        aux_new.syndrome = syn_expect ? EVENT_I.syndrome : 8'h00;
        // uncorrected leaves the field undefined; zero is the quiet choice
        if (EVENT_I.uncorrected || !EVENT_I.thr_track) begin
            aux_new.thr = error_bank_pkg::THR_NONE;
        end else if (EVENT_I.thr_above) begin
            aux_new.thr = error_bank_pkg::THR_YELLOW;
        end else begin
            aux_new.thr = error_bank_pkg::THR_GREEN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: bus first, events after, so a set beats a same-cycle clear
    always_comb begin
        next_state = state;
        if (CE_I) begin
            // register read, answer held until the next read
            if (RD_I) begin
                if (ADDR_I == error_bank_pkg::ADDR_STATUS_LO) begin
                    next_state.rd_data = state.status[31:0];
                end else if (ADDR_I == error_bank_pkg::ADDR_STATUS_HI) begin
                    next_state.rd_data = state.status[63:32];
                end else if (ADDR_I == error_bank_pkg::ADDR_IRQ_STAT) begin
                    next_state.rd_data = {29'h0000_0000, state.irq_stat};
                    next_state.irq_stat = error_bank_pkg::IRQ_RESET;
                end else if (ADDR_I == error_bank_pkg::ADDR_IRQ_MASK) begin
                    next_state.rd_data = {29'h0000_0000, state.irq_mask};
                end else begin
                    next_state.rd_data = error_bank_pkg::RD_RESET;
                end
            end
            // register write; writing zero clears the sticky log flags
            if (WR_I) begin
                if (ADDR_I == error_bank_pkg::ADDR_STATUS_HI) begin
                    if (!WDATA_I[error_bank_pkg::HI_VAL_BIT]) begin
                        next_state.status.val = 1'b0;
                    end
                    if (!WDATA_I[error_bank_pkg::HI_OVER_BIT]) begin
                        next_state.status.over = 1'b0;
                    end
                end else if (ADDR_I == error_bank_pkg::ADDR_IRQ_MASK) begin
                    next_state.irq_mask = WDATA_I[2:0];
                end
            end
            // error event
            if (EVENT_I.valid) begin
                next_state.status.val = 1'b1;
                next_state.irq_stat[error_bank_pkg::IRQ_LOGGED] = 1'b1;
                if (state.status.val) begin
                    next_state.status.over = 1'b1;
                    next_state.irq_stat[error_bank_pkg::IRQ_OVER] = 1'b1;
                end
                if (bump && count == 8'hFE) begin
                    next_state.irq_stat[error_bank_pkg::IRQ_SAT] = 1'b1;
                end
                // count mirror follows even when the old entry is kept
                next_state.status.aux.count = aux_new.count;
                if (take_ev) begin
                    next_state.status.aux = aux_new;
                    next_state.status.uc = EVENT_I.uncorrected;
                    next_state.status.misc_valid = EVENT_I.misc_valid;
                    next_state.status.pcc = EVENT_I.pcc;
                    next_state.status.en = EVENT_I.en;
                    next_state.status.addrv = EVENT_I.addrv;
                    next_state.status.machine_check_arch = EVENT_I.mca_code;
                    next_state.status.model = EVENT_I.is_l3 ? l3_word : EVENT_I.model_code;
                end
            end
            next_state.irq = |(next_state.irq_stat & next_state.irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state.status <= error_bank_pkg::STATUS_RESET;
            state.irq_stat <= error_bank_pkg::IRQ_RESET;
            state.irq_mask <= error_bank_pkg::IRQ_RESET;
            state.rd_data <= error_bank_pkg::RD_RESET;
            state.irq <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state register
    assign RD_DATA_O = state.rd_data;
    assign STATUS_O = state.status;
    assign IRQ_O = state.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (SYS_RST_I);

    AST_AUX_SAME: assert property (
        take_ev |=> (STATUS_O.aux == $past(aux_new)))
        else $error("auxiliary field differs by error type");

    AST_COUNT_FIRST: assert property (
        (CE_I && bump && count == error_bank_pkg::COUNT_RESET) |=>
        (STATUS_O.aux.count == error_bank_pkg::COUNT_FIRST))
        else $error("first correctable event did not read one");

    AST_COUNT_HOLD: assert property (
        (CE_I && !EVENT_I.valid) |=> $stable(STATUS_O.aux.count))
        else $error("count mirror moved with no event");

    AST_MISC_FMT: assert property (
        !STATUS_O.misc_valid |-> (STATUS_O.aux.misc_fmt == 2'h0))
        else $error("misc format set while misc info invalid");

    AST_MISC_INFO_VALID: assert property (
        take_ev |=> (STATUS_O.misc_valid == $past(ev_misc_info_valid)))
        else $error("misc valid not taken from event");

    AST_SYNDROME: assert property (
        !STATUS_O.aux.syn_valid |-> (STATUS_O.aux.syndrome == 8'h00))
        else $error("syndrome present without valid bit");

    AST_SYN_VALID: assert property (
        take_ev |=> (STATUS_O.aux.syn_valid == $past(syn_expect)))
        else $error("syndrome valid bit wrong");

    AST_THR_RSVD: assert property (
        STATUS_O.aux.thr != error_bank_pkg::THR_RSVD)
        else $error("reserved threshold code produced");

    AST_THR_UC: assert property (
        STATUS_O.uc |-> (STATUS_O.aux.thr == error_bank_pkg::THR_NONE))
        else $error("threshold status set with uncorrected error");

    AST_L3_NONE: assert property (
        (take_ev && EVENT_I.is_l3 && l3_expect == error_bank_pkg::L3_NONE) |=>
        (STATUS_O.model[2:0] == error_bank_pkg::L3_NONE))
        else $error("level-3 no-error code wrong");

    AST_L3_MIXED: assert property (
        (take_ev && EVENT_I.is_l3 && (EVENT_I.ce_one || EVENT_I.ce_multi) &&
        (EVENT_I.ue_one || EVENT_I.ue_multi)) |=> (STATUS_O.model[2:0] == error_bank_pkg::L3_MIXED))
        else $error("level-3 mixed code wrong");

    AST_L3_PATTERN: assert property (
        (take_ev && EVENT_I.is_l3) |=>
        (STATUS_O.model[15:5] == error_bank_pkg::L3_FIXED && STATUS_O.model[4:3] == 2'h0))
        else $error("level-3 fixed pattern wrong");

    AST_UC_FLAG: assert property (
        take_ev |=> (STATUS_O.uc == $past(ev_uc)))
        else $error("uncorrected flag not taken from event");

    AST_LOG_VALID: assert property (
        (CE_I && EVENT_I.valid) |=> STATUS_O.val)
        else $error("log valid not set after an event");

    AST_RSVD_ZERO: assert property (
        STATUS_O.aux.rsvd_lo == 2'h0 && STATUS_O.aux.rsvd_hi == 2'h0)
        else $error("reserved auxiliary bits not zero");

    AST_RD_MASK: assert property (
        (CE_I && RD_I && ADDR_I == error_bank_pkg::ADDR_IRQ_MASK) |=>
        (RD_DATA_O == {29'h0000_0000, $past(state.irq_mask)}))
        else $error("mask read answer wrong");

    COV_OVER: cover property (CE_I && EVENT_I.valid && STATUS_O.val);
    COV_L3_MIXED: cover property (take_ev && EVENT_I.is_l3 && l3_expect == error_bank_pkg::L3_MIXED);
    COV_KEEP_UC: cover property (CE_I && EVENT_I.valid && keep_old);
    COV_IRQ: cover property (IRQ_O ##1 (CE_I && RD_I && ADDR_I == error_bank_pkg::ADDR_IRQ_STAT));

endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic CLOCK_I;
    logic SYS_RST_I;
    logic CE_I;
    error_bank_pkg::ev_s EVENT_I;
    logic [3:0] ADDR_I;
    logic [31:0] WDATA_I;
    logic WR_I;
    logic RD_I;
    logic [31:0] RD_DATA_O;
    error_bank_pkg::status_s STATUS_O;
    logic IRQ_O;
    error_bank_pkg::status_s exp_st;
    error_bank_pkg::ev_s ev;
    logic [2:0] exp_irq;
    logic [2:0] exp_mask;
    logic [15:0] seed;
    int cnt;
    int err_count;
    int comparisons;
    int cycles;

    error_bank_info_formatter i_dut (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I), .EVENT_I(EVENT_I),
        .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O),
        .STATUS_O(STATUS_O), .IRQ_O(IRQ_O));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the whole run needs well under 3000 cycles
    initial begin
        CLOCK_I = 1'b0;
        forever #5 CLOCK_I = ~CLOCK_I;
    end

    always @(posedge CLOCK_I) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // comparison, reporting and stimulus helpers
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // random event word; valid forced so every call is a real event
    task automatic rnd_ev(output error_bank_pkg::ev_s e);
        logic [63:0] w;
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            w = {w[47:0], seed};
        end
        e = error_bank_pkg::ev_s'(w[56:0]);
        e.valid = 1'b1;
    endtask

    // level-3 code worked out from the way flags, mixed first
    function automatic logic [2:0] exp_code(input error_bank_pkg::ev_s e);
        int ce;
        int ue;
        ce = int'(e.ce_one) + int'(e.ce_multi);
        ue = int'(e.ue_one) + int'(e.ue_multi);
        if (ce > 0 && ue > 0) return 3'h7;
        if (e.ue_multi) return 3'h2;
        if (e.ue_one) return 3'h6;
        if (e.ce_multi) return 3'h1;
        if (e.ce_one) return 3'h5;
        if (e.tag_multi) return 3'h3;
        return 3'h0;
    endfunction

    task automatic check_irq();
        check("irq level", 64'(IRQ_O), 64'(|(exp_irq & exp_mask)));
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLOCK_I);
        WR_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= d;
        @(posedge CLOCK_I);
        WR_I <= 1'b0;
        if (a == 4'h1) begin
            exp_st.val = exp_st.val & d[31];
            exp_st.over = exp_st.over & d[30];
        end
        if (a == 4'h3) exp_mask = d[2:0];
        #1;
        check_irq();
    endtask

    task automatic bus_rd(input logic [3:0] a);
        logic [31:0] e;
        case (a)
            4'h0: e = exp_st[31:0];
            4'h1: e = exp_st[63:32];
            4'h2: e = 32'(exp_irq);
            4'h3: e = 32'(exp_mask);
            default: e = 32'h0000_0000;
        endcase
        @(posedge CLOCK_I);
        RD_I <= 1'b1;
        ADDR_I <= a;
        @(posedge CLOCK_I);
        RD_I <= 1'b0;
        if (a == 4'h2) exp_irq = 3'h0;
        #1;
        check("read data", 64'(RD_DATA_O), 64'(e));
        check_irq();
    endtask

    // one event pulse, then the bench model steps and the status word is compared
    task automatic send_ev(input error_bank_pkg::ev_s e);
        logic keep;
        @(posedge CLOCK_I);
        EVENT_I <= e;
        @(posedge CLOCK_I);
        EVENT_I.valid <= 1'b0;
        keep = exp_st.val && exp_st.uc && !e.uncorrected;
        exp_irq[0] = 1'b1;
        if (exp_st.val) exp_irq[1] = 1'b1;
        if (!e.uncorrected && cnt < 255) begin
            cnt = cnt + 1;
            if (cnt == 255) exp_irq[2] = 1'b1;
        end
        exp_st.over = exp_st.over | exp_st.val;
        exp_st.val = 1'b1;
        exp_st.aux.count = cnt[7:0];
        if (!keep) begin
            exp_st.uc = e.uncorrected;
            exp_st.pcc = e.pcc;
            exp_st.en = e.en;
            exp_st.addrv = e.addrv;
            exp_st.misc_valid = e.misc_valid;
            exp_st.aux.misc_fmt = e.misc_valid ? e.misc_fmt : 2'h0;
            exp_st.aux.syn_valid = e.ecc_syn_valid & !e.uncorrected;
            exp_st.aux.syndrome = exp_st.aux.syn_valid ? e.syndrome : 8'h00;
            exp_st.aux.thr = (e.uncorrected || !e.thr_track) ? 2'h0 : (e.thr_above ? 2'h2 : 2'h1);
            exp_st.model = e.is_l3 ? {11'h100, 2'h0, exp_code(e)} : e.model_code;
            exp_st.machine_check_arch = e.mca_code;
        end
        #1;
        check("status word", STATUS_O, exp_st);
        check("reserved aux", 64'({STATUS_O[56:55], STATUS_O[43:42]}), 64'h0000_0000_0000_0000);
        check_irq();
    endtask

    task automatic do_reset();
        SYS_RST_I <= 1'b1;
        repeat (16) @(posedge CLOCK_I);
        SYS_RST_I <= 1'b0;
        exp_st = '0;
        exp_irq = 3'h0;
        exp_mask = 3'h0;
        cnt = 0;
        #1;
        check("status after reset", STATUS_O, 64'h0000_0000_0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        SYS_RST_I = 1'b1;
        CE_I = 1'b1;
        EVENT_I = '0;
        ADDR_I = 4'h0;
        WDATA_I = 32'h0000_0000;
        WR_I = 1'b0;
        RD_I = 1'b0;
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        seed = 16'hD3F6;
        do_reset();
        for (int a = 0; a < 16; a++) bus_rd(4'(a));
        bus_wr(4'h3, 32'hFFFF_FFF8);
        bus_rd(4'h3);
        bus_wr(4'h3, 32'h0000_0007);
        $display("test registers done");
        // first corrected event must read a count of one
        rnd_ev(ev);
        ev.uncorrected = 1'b0;
        send_ev(ev);
        for (int k = 0; k < 48; k++) begin
            rnd_ev(ev);
            send_ev(ev);
            bus_rd(4'h0);
            bus_rd(4'h1);
            if (k % 4 == 3) bus_rd(4'h2);
            if (k % 3 == 2) bus_wr(4'h1, {1'b0, k[0], 30'h0000_0000});
            if (k == 20) bus_wr(4'h0, 32'hFFFF_FFFF);
        end
        $display("test random events done");
        for (int k = 0; k < 32; k++) begin
            rnd_ev(ev);
            ev.is_l3 = 1'b1;
            {ev.ce_one, ev.ce_multi, ev.ue_one, ev.ue_multi, ev.tag_multi} = k[4:0];
            bus_wr(4'h1, 32'h0000_0000);
            send_ev(ev);
            check("fixed code bits", 64'(STATUS_O[31:19]), 64'({11'h100, 2'h0}));
        end
        $display("test level3 codes done");
        // a frozen clock enable must drop both the event and the write
        rnd_ev(ev);
        @(posedge CLOCK_I);
        CE_I <= 1'b0;
        EVENT_I <= ev;
        WR_I <= 1'b1;
        ADDR_I <= 4'h3;
        WDATA_I <= 32'h0000_0000;
        @(posedge CLOCK_I);
        CE_I <= 1'b1;
        EVENT_I.valid <= 1'b0;
        WR_I <= 1'b0;
        #1;
        check("frozen status", STATUS_O, exp_st);
        bus_rd(4'h3);
        $display("test clock enable done");
        bus_rd(4'h2);
        // enough corrected events to reach 255 from any start, then push past it
        for (int k = 0; k < 260; k++) begin
            rnd_ev(ev);
            ev.uncorrected = 1'b0;
            send_ev(ev);
        end
        check("saturated count", 64'(STATUS_O.aux.count), 64'h0000_0000_0000_00FF);
        bus_rd(4'h2);
        bus_rd(4'h2);
        $display("test saturation done");
        do_reset();
        bus_rd(4'h1);
        rnd_ev(ev);
        ev.uncorrected = 1'b0;
        send_ev(ev);
        $display("test cold reset done");
        end_of_test();
    end
endmodule
